// ### design/mbd_dec_unit.v
// Decrement arithmetic with zero detection
`include "mbd_defines.vh"
`default_nettype none
module mbd_dec_unit (
  input  wire [7:0] operand,
  output wire [7:0] result,
  output wire       zero
);
  // Pure combinational: one-cycle ops need the result within the cycle
  assign result = operand - `MBD_ONE8;
  assign zero   = (result == `MBD_ZERO8);
endmodule
`default_nettype wire

// ### design/mbd_defines.vh
// Constants for the branch, decrement and interrupt-control execution block
`ifndef MBD_DEFINES_VH
`define MBD_DEFINES_VH
// ****************************************************************
// Operation codes presented by the decode stage
// ****************************************************************
`define MBD_OP_W          3
`define MBD_OP_NONE       3'h0
`define MBD_OP_DEC        3'h1
`define MBD_OP_IRQ_DIS    3'h2
`define MBD_OP_IRQ_EN     3'h3
`define MBD_OP_LBRANCH    3'h4
`define MBD_OP_LCALL      3'h5
`define MBD_OP_CBRANCH    3'h6
// ****************************************************************
// Widths and field positions
// ****************************************************************
`define MBD_PC_W          12
`define MBD_ADDR_W        7
`define MBD_DATA_W        8
`define MBD_TABLE_HIGH_POINTER_HI       2
`define MBD_PC_HI_W       3
`define MBD_ONE8          8'h01
`define MBD_ZERO8         8'h00
`define MBD_ONE12         12'h001
`define MBD_PC_RST        12'h000
`endif

// ### design/mbd_exec.v
// Execution block for decrement, interrupt enable control and long branches
`include "mbd_defines.vh"
`default_nettype none
module mbd_exec (
  input  wire        clock,
  input  wire        rst,
  input  wire        op_valid,
  input  wire [2:0]  op_code,
  input  wire        dest_bit,
  input  wire [6:0]  reg_addr,
  input  wire [11:0] target_addr,
  input  wire [7:0]  reg_rdata,
  input  wire [7:0]  accumulator,
  input  wire [7:0]  table_high_pointer,
  input  wire [11:0] pc_current,
  output reg         busy,
  output reg         reg_we,
  output reg  [6:0]  reg_waddr,
  output reg  [7:0]  reg_wdata,
  output reg         acc_we,
  output reg  [7:0]  acc_wdata,
  output reg         zero_we,
  output reg         zero_flag,
  output reg         global_irq_enable_bit,
  output reg         pc_load,
  output reg  [11:0] pc_target,
  output reg         stack_push,
  output reg  [11:0] stack_data
);
  // ****************************************************************
  // State machine
  // ****************************************************************
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_FLUSH = 2'b10;

  reg  [1:0] state_q;
  wire [7:0] dec_result;
  wire       dec_zero;

  mbd_dec_unit u_dec (
    .operand (reg_rdata),
    .result  (dec_result),
    .zero    (dec_zero)
  );

  wire take = op_valid && (state_q == ST_IDLE);

  // Branches take a second cycle to discard the prefetched word
  always @(posedge clock) begin
    if (rst) begin
      state_q <= ST_IDLE;
      busy    <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take && (op_code == `MBD_OP_LBRANCH || op_code == `MBD_OP_LCALL ||
                       op_code == `MBD_OP_CBRANCH)) begin
            state_q <= ST_FLUSH;
            busy    <= 1'b1;
          end
        end
        ST_FLUSH: begin
          state_q <= ST_IDLE;
          busy    <= 1'b0;
        end
        default: begin
          state_q <= ST_IDLE;
          busy    <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Result strobes, one-cycle pulses from flip-flops; global_irq_enable_bit is a held level
  // ****************************************************************
  always @(posedge clock) begin
    if (rst) begin
      reg_we     <= 1'b0;
      reg_waddr  <= 7'h00;
      reg_wdata  <= `MBD_ZERO8;
      acc_we     <= 1'b0;
      acc_wdata  <= `MBD_ZERO8;
      zero_we    <= 1'b0;
      zero_flag  <= 1'b0;
      pc_load    <= 1'b0;
      pc_target  <= `MBD_PC_RST;
      stack_push <= 1'b0;
      stack_data <= `MBD_PC_RST;
      global_irq_enable_bit <= 1'b0;
    end else begin
      reg_we     <= 1'b0;
      acc_we     <= 1'b0;
      zero_we    <= 1'b0;
      pc_load    <= 1'b0;
      stack_push <= 1'b0;
      if (take) begin
        case (op_code)
          `MBD_OP_DEC: begin
            reg_waddr <= reg_addr;
            reg_wdata <= dec_result;
            acc_wdata <= dec_result;
            reg_we    <= dest_bit;
            acc_we    <= !dest_bit;
            zero_we   <= 1'b1;
            zero_flag <= dec_zero;
          end
          `MBD_OP_IRQ_DIS: global_irq_enable_bit <= 1'b0;
          `MBD_OP_IRQ_EN:  global_irq_enable_bit <= 1'b1;
          `MBD_OP_LBRANCH: begin
            pc_load   <= 1'b1;
            pc_target <= target_addr;
          end
          `MBD_OP_LCALL: begin
            stack_push <= 1'b1;
            stack_data <= pc_current + `MBD_ONE12;
            pc_load    <= 1'b1;
            pc_target  <= target_addr;
          end
          `MBD_OP_CBRANCH: begin
            pc_load   <= 1'b1;
            // Bit 11 stays from the current page
            pc_target <= {pc_current[11], table_high_pointer[`MBD_TABLE_HIGH_POINTER_HI:0], accumulator};
          end
          default: begin
            pc_load <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/mbd_exec_assertions.sv
// Checker for the execution block
`include "mbd_defines.vh"
`default_nettype none
module mbd_exec_chk (
  input wire logic        clock, rst, op_valid, dest_bit, busy, reg_we, acc_we, zero_we, zero_flag,
  input wire logic        global_irq_enable_bit, pc_load, stack_push,
  input wire logic [2:0]  op_code,
  input wire logic [6:0]  reg_addr, reg_waddr,
  input wire logic [7:0]  reg_rdata, accumulator, table_high_pointer, reg_wdata, acc_wdata,
  input wire logic [11:0] target_addr, pc_current, pc_target, stack_data
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Only ops taken while idle count; busy ones are dropped
  wire logic t = op_valid && !busy;
  dec_acc_a: assert property (t && op_code == `MBD_OP_DEC && !dest_bit |=>
    acc_we && !reg_we && acc_wdata == $past(reg_rdata) - 8'h01) else $error("dec to acc wrong");
  dec_reg_a: assert property (t && op_code == `MBD_OP_DEC && dest_bit |=>
    reg_we && !acc_we && reg_waddr == $past(reg_addr) && reg_wdata == $past(reg_rdata) - 8'h01) else $error("dec reg");
  dec_zero_a: assert property (t && op_code == `MBD_OP_DEC |=>
    zero_we && !busy && zero_flag == ($past(reg_rdata) == 8'h01)) else $error("dec zero wrong");
  irq_off_a: assert property (t && op_code == `MBD_OP_IRQ_DIS |=> !global_irq_enable_bit && !zero_we)
    else $error("irq disable wrong");
  irq_on_a: assert property (t && op_code == `MBD_OP_IRQ_EN |=> global_irq_enable_bit && !zero_we)
    else $error("irq enable wrong");
  long_branch_a: assert property (t && op_code == `MBD_OP_LBRANCH |=>
    pc_load && busy && !zero_we && pc_target == $past(target_addr) ##1 !busy) else $error("long branch wrong");
  long_call_a: assert property (t && op_code == `MBD_OP_LCALL |=>
    stack_push && pc_load && stack_data == $past(pc_current) + 12'h001 && pc_target == $past(target_addr))
    else $error("long call wrong");
  comp_branch_a: assert property (t && op_code == `MBD_OP_CBRANCH |=>
    pc_load && pc_target[10:0] == 11'({$past(table_high_pointer), $past(accumulator)})) else $error("cbranch");
endmodule
bind mbd_exec mbd_exec_chk i_mbd_exec_chk (.*);
`default_nettype wire

// ### verification/tb_mbd_exec.sv
// Self-checking bench for the execution block
`include "mbd_defines.vh"
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin fail_count++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_mbd_exec;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 0, rst = 1, op_valid = 0, dest_bit = 0, irq = 0;
  logic [2:0]  op_code = 0;
  logic [6:0]  reg_addr = 0;
  logic [7:0]  reg_rdata = 0, accumulator = 0, table_high_pointer = 0;
  logic [11:0] target_addr = 0, pc_current = 0;
  wire logic   busy, reg_we, acc_we, zero_we, zero_flag, global_irq_enable_bit, pc_load, stack_push;
  wire logic [6:0]  reg_waddr;
  wire logic [7:0]  reg_wdata, acc_wdata;
  wire logic [11:0] pc_target, stack_data;
  int          seed = 68, fail_count = 0, checked = 0;
  logic [29:0] q[$], exp_v;
  // Fields a strobe does not qualify are masked, since they may hold stale data
  wire logic [29:0] obs = {reg_we, acc_we, pc_load, stack_push, global_irq_enable_bit,
    pc_load ? pc_target : {4'h0, reg_we ? reg_wdata : acc_wdata}, stack_push ? stack_data : 12'h000, !pc_load && zero_flag};
  mbd_exec i_mbd_exec (.*);
  initial forever #50 clock = ~clock;
  // Monitor: settled at the falling edge after the taking edge
  always @(negedge clock) if (reg_we | acc_we | pc_load) begin
    exp_v = q.size() ? q.pop_front() : 'x;
    `CHK("result", exp_v, obs)
  end
  // Present one op and note what it should produce
  task automatic run_op(input logic [2:0] c, input logic d);
    @(negedge clock);
    op_valid = 1;
    op_code = c;
    dest_bit = d;
    {reg_addr, target_addr, pc_current, accumulator, table_high_pointer} = {$random(seed), $random(seed)};
    reg_rdata = $random(seed) & 8'h83;
    if (c == `MBD_OP_IRQ_DIS || c == `MBD_OP_IRQ_EN) irq = c[0];
    else if (c == `MBD_OP_DEC) q.push_back({d, !d, 2'h0, irq, 4'h0, reg_rdata - 8'h01, 12'h000, reg_rdata == 8'h01});
    else q.push_back({3'h1, c == `MBD_OP_LCALL, irq, c == `MBD_OP_CBRANCH ?
      {pc_current[11], table_high_pointer[2:0], accumulator} : target_addr, c == `MBD_OP_LCALL ? pc_current + 12'h001 : 12'h000, 1'b0});
    if (c >= `MBD_OP_LBRANCH) begin
      @(negedge clock);
      op_code = `MBD_OP_DEC; // Offered while busy, so no result may follow
    end
  endtask
  task automatic end_of_test;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clock);
    rst = 0;
    for (int i = 0; i < 80; i++) run_op(3'(1 + {$random(seed)} % 6), $random(seed));
    @(negedge clock);
    op_valid = 0;
    repeat (4) @(negedge clock);
    end_of_test;
  end
  // Watchdog well past the longest op sequence
  initial begin
    #50000;
    fail_count++;
    end_of_test;
  end
endmodule
`default_nettype wire
